// file: rtl/src_map.vh
`ifndef SRC_MAP_VH
`define SRC_MAP_VH

// register byte offsets
`define SRC_CMD_OFS 8'h00
`define SRC_STAT_OFS 8'h04
`define SRC_MODE_OFS 8'h08

// write password, upper byte of command and mode writes
`define SRC_KEY_HI 31
`define SRC_KEY_LO 24
`define SRC_KEY_VAL 8'ha5

// command register bits
`define SRC_CMD_CPU 0
`define SRC_CMD_PERIPH 2
`define SRC_CMD_PIN 3

// status register fields
`define SRC_ST_SEEN 0
`define SRC_ST_CAUSE_LO 8
`define SRC_ST_CAUSE_HI 10
`define SRC_ST_LEVEL 16
`define SRC_ST_BUSY 17

// mode register fields
`define SRC_MD_UEN 0
`define SRC_MD_IEN 4
`define SRC_MD_EXP_LO 8
`define SRC_MD_EXP_HI 11
`define SRC_MODE_RST 32'h0000_0000

// reset cause codes
`define SRC_CAUSE_GEN 3'h0
`define SRC_CAUSE_WAKE 3'h1
`define SRC_CAUSE_WDOG 3'h2
`define SRC_CAUSE_SW 3'h3
`define SRC_CAUSE_USER 3'h4

// timing in slow clock cycles
`define SRC_STARTUP_CYC 64
`define SRC_HOLD_CYC 2'h2
`define SRC_BOOT_CYC 2'h3

`endif

// file: rtl/src_reset_ctrl.v
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// Summary of operation
// - pin sampled each clock; low reports user reset; level readable in status
// - user reset enable at 0 stops pin low from causing user reset
// - pin assertion flag set on falling pin, cleared only by status read
// - interrupt enable at 1 turns pin assertion into interrupt, not reset
// - pin pulse lasts 2 to the power (length field plus one) cycles
// - mode register kept through wake-up resets while backup supply stays
// - boot select sampled three cycles after core supply reset rises
// - reset cause updated when processor reset releases
// - backup supply reset rise filtered by fixed startup counter
// - after startup all resets held two more cycles, cause reads general
// - pin released two cycles after backup reset release with default length
// - backup supply low asserts every reset output at once
// - core supply reset only after backup reset is released
// - core supply low asserts all but backup; wake-up after two cycles
// - wake-up reset drives pin for programmed pulse length
// - core supply falling asserts resets at once with its detector
// - pin low with enable set enters user reset, processor and peripherals
// - user reset left after pin high, resync and two cycle startup
// - user reset release loads cause code four
// - pin held low outside keeps internal resets until it rises
// - command bits reset processor, peripherals, pin; may be combined
// - software reset entered by any command bit, lasts two cycles
// - command write needs password byte a5, otherwise ignored
// - cause codes: general 0, wake 1, watchdog 2, software 3, user 4
`include "src_map.vh"

module src_reset_ctrl #(
	parameter STARTUP_CYC = `SRC_STARTUP_CYC,
	parameter CNT_W = 17
) (
	input wire CORE_CLK,
	input wire RESET_N,
	input wire BACKUP_POR_N,
	input wire CORE_POR_N,
	input wire PIN_RST_IN,
	output wire PIN_RST_OUT,
	output wire PIN_RST_OE,
	input wire BOOT_SELECT_PIN,
	output wire BOOT_SELECT,
	output wire PROC_RESET_N,
	output wire BACKUP_RESET_N,
	output wire PERIPH_RESET_N,
	output wire USER_RESET_IRQ,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR
);

localparam ST_START = 8'h01;
localparam ST_GHOLD = 8'h02;
localparam ST_CDOWN = 8'h04;
localparam ST_WAKE = 8'h08;
localparam ST_RUN = 8'h10;
localparam ST_USER = 8'h20;
localparam ST_UREL = 8'h40;
localparam ST_SW = 8'h80;

////////////////////////////////////////////////////////////////////////
// reset domains: backup supply cell, then core supply cell inside it

// gating the reset tree is deliberate: supply loss must act without a clock
wire bu_rst_n = RESET_N & BACKUP_POR_N;
wire core_rst_n = bu_rst_n & CORE_POR_N;

reg [7:0] state_reg;
reg [7:0] state_next;
reg [CNT_W-1:0] start_cnt_reg;
reg [CNT_W-1:0] start_cnt_next;
reg [1:0] hold_reg;
reg [1:0] hold_next;
reg [2:0] cause_reg;
reg [2:0] cause_next;
reg [2:0] cmd_reg;
reg [2:0] cmd_next;
reg [CNT_W-1:0] pulse_reg;
reg [CNT_W-1:0] pulse_next;
reg bu_out_reg;
reg bu_out_next;
reg [2:0] own_reg;
reg por_s1_reg;
reg por_s2_reg;
reg pin_s1_reg;
reg pin_s2_reg;
reg pin_d_reg;
reg seen_reg;
reg seen_next;
reg uen_reg;
reg ien_reg;
reg [3:0] exp_reg;
reg [31:0] rdata_reg;
reg proc_n_reg;
reg periph_n_reg;
reg [1:0] boot_cnt_reg;
reg boot_s1_reg;
reg boot_s2_reg;
reg boot_reg;
reg core_ok_s1_reg;
reg core_ok_s2_reg;

////////////////////////////////////////////////////////////////////////
// bus decode

wire setup = PSEL & ~PENABLE;
wire access = PSEL & PENABLE;
wire hit_cmd = (PADDR == `SRC_CMD_OFS);
wire hit_stat = (PADDR == `SRC_STAT_OFS);
wire hit_mode = (PADDR == `SRC_MODE_OFS);
wire key_ok = (PWDATA[`SRC_KEY_HI:`SRC_KEY_LO] == `SRC_KEY_VAL);
wire wr_cmd = access & PWRITE & hit_cmd & key_ok;
wire wr_mode = access & PWRITE & hit_mode & key_ok;
wire rd_stat = access & ~PWRITE & hit_stat;
wire [2:0] cmd_bits = {PWDATA[`SRC_CMD_PIN], PWDATA[`SRC_CMD_PERIPH],
	PWDATA[`SRC_CMD_CPU]};
// commands only while running; a busy or held processor cannot issue one
wire sw_go = wr_cmd & (|cmd_bits) & (state_reg == ST_RUN);

assign PREADY = 1'b1;
assign PSLVERR = access & ~(hit_cmd | hit_stat | hit_mode);
assign PRDATA = rdata_reg;

////////////////////////////////////////////////////////////////////////
// pin and supply synchronisers

always @(posedge CORE_CLK or negedge bu_rst_n) begin
	if (!bu_rst_n) begin
		por_s1_reg <= 1'b0;
		por_s2_reg <= 1'b0;
		pin_s1_reg <= 1'b1;
		pin_s2_reg <= 1'b1;
		pin_d_reg <= 1'b1;
	end else begin
		por_s1_reg <= CORE_POR_N;
		por_s2_reg <= por_s1_reg;
		pin_s1_reg <= PIN_RST_IN;
		pin_s2_reg <= pin_s1_reg;
		pin_d_reg <= pin_s2_reg;
	end
end

wire pin_fall = pin_d_reg & ~pin_s2_reg;
// own pulse is seen back through the synchroniser; mask it
wire own_drive = (pulse_reg != {CNT_W{1'b0}}) | (|own_reg);
wire user_go = ~pin_s2_reg & uen_reg & ~ien_reg & ~own_drive;
wire [4:0] exp_p1 = {1'b0, exp_reg} + 5'h01;
wire [CNT_W-1:0] pulse_len = {{(CNT_W-1){1'b0}}, 1'b1} << exp_p1;

////////////////////////////////////////////////////////////////////////
// reset state manager

always @* begin
	state_next = state_reg;
	start_cnt_next = start_cnt_reg;
	hold_next = hold_reg + 2'h1;
	cause_next = cause_reg;
	cmd_next = cmd_reg;
	bu_out_next = bu_out_reg;
	pulse_next = pulse_reg;
	if (pulse_reg != {CNT_W{1'b0}}) begin
		pulse_next = pulse_reg - {{(CNT_W-1){1'b0}}, 1'b1};
	end
	case (state_reg)
	ST_START: begin
		start_cnt_next = start_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		if (start_cnt_reg == STARTUP_CYC - 1) begin
			state_next = ST_GHOLD;
			hold_next = 2'h0;
		end
	end
	ST_GHOLD: begin
		if (hold_reg == `SRC_HOLD_CYC - 2'h1) begin
			state_next = ST_RUN;
			bu_out_next = 1'b1;
			cause_next = `SRC_CAUSE_GEN;
			pulse_next = pulse_len;
		end
	end
	ST_CDOWN: begin
		if (por_s2_reg) begin
			state_next = ST_WAKE;
			hold_next = 2'h0;
		end
	end
	ST_WAKE: begin
		if (hold_reg == `SRC_HOLD_CYC - 2'h1) begin
			state_next = ST_RUN;
			cause_next = `SRC_CAUSE_WAKE;
			pulse_next = pulse_len;
		end
	end
	ST_RUN: begin
		if (sw_go) begin
			state_next = ST_SW;
			hold_next = 2'h0;
			cmd_next = cmd_bits;
			if (cmd_bits[2]) begin
				pulse_next = pulse_len;
			end
		end else if (user_go) begin
			state_next = ST_USER;
			pulse_next = pulse_len;
		end
	end
	ST_USER: begin
		if (pin_s2_reg) begin
			state_next = ST_UREL;
			hold_next = 2'h0;
		end
	end
	ST_UREL: begin
		if (!pin_s2_reg) begin
			state_next = ST_USER;
		end else if (hold_reg == `SRC_HOLD_CYC - 2'h1) begin
			state_next = ST_RUN;
			cause_next = `SRC_CAUSE_USER;
		end
	end
	ST_SW: begin
		if (hold_reg == `SRC_HOLD_CYC - 2'h1) begin
			state_next = ST_RUN;
			if (cmd_reg[0]) begin
				cause_next = `SRC_CAUSE_SW;
			end
		end
	end
	default: begin
		state_next = ST_START;
	end
	endcase
	// core supply loss outranks everything once backup is up
	if (bu_out_reg && !por_s2_reg && state_reg != ST_CDOWN) begin
		state_next = ST_CDOWN;
	end
end

always @(posedge CORE_CLK or negedge bu_rst_n) begin
	if (!bu_rst_n) begin
		state_reg <= ST_START;
		start_cnt_reg <= {CNT_W{1'b0}};
		hold_reg <= 2'h0;
		cause_reg <= `SRC_CAUSE_GEN;
		cmd_reg <= 3'h0;
		bu_out_reg <= 1'b0;
		pulse_reg <= {CNT_W{1'b0}};
		own_reg <= 3'h0;
	end else begin
		state_reg <= state_next;
		start_cnt_reg <= start_cnt_next;
		hold_reg <= hold_next;
		cause_reg <= cause_next;
		cmd_reg <= cmd_next;
		bu_out_reg <= bu_out_next;
		pulse_reg <= pulse_next;
		own_reg <= {own_reg[1:0], PIN_RST_OE};
	end
end

////////////////////////////////////////////////////////////////////////
// retained mode register and status flag, backup domain

always @* begin
	seen_next = seen_reg;
	// only a flag that the read returned is cleared, so a new edge survives
	if (rd_stat && rdata_reg[`SRC_ST_SEEN]) begin
		seen_next = 1'b0;
	end
	if (pin_fall) begin
		seen_next = 1'b1;
	end
end

always @(posedge CORE_CLK or negedge bu_rst_n) begin
	if (!bu_rst_n) begin
		seen_reg <= 1'b0;
		uen_reg <= 1'b0;
		ien_reg <= 1'b0;
		exp_reg <= 4'h0;
		rdata_reg <= 32'h0000_0000;
	end else begin
		seen_reg <= seen_next;
		if (wr_mode) begin
			uen_reg <= PWDATA[`SRC_MD_UEN];
			ien_reg <= PWDATA[`SRC_MD_IEN];
			exp_reg <= PWDATA[`SRC_MD_EXP_HI:`SRC_MD_EXP_LO];
		end
		if (setup) begin
			rdata_reg <= 32'h0000_0000;
			if (hit_stat) begin
				rdata_reg[`SRC_ST_SEEN] <= seen_reg;
				rdata_reg[`SRC_ST_CAUSE_HI:`SRC_ST_CAUSE_LO] <= cause_reg;
				rdata_reg[`SRC_ST_LEVEL] <= pin_s2_reg;
				rdata_reg[`SRC_ST_BUSY] <= (state_reg == ST_SW);
			end
			if (hit_mode) begin
				rdata_reg[`SRC_MD_UEN] <= uen_reg;
				rdata_reg[`SRC_MD_IEN] <= ien_reg;
				rdata_reg[`SRC_MD_EXP_HI:`SRC_MD_EXP_LO] <= exp_reg;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// core domain release
// a short core supply dip must not free the processor before wake-up starts

always @(posedge CORE_CLK or negedge core_rst_n) begin
	if (!core_rst_n) begin
		core_ok_s1_reg <= 1'b0;
		core_ok_s2_reg <= 1'b0;
	end else begin
		core_ok_s1_reg <= 1'b1;
		core_ok_s2_reg <= core_ok_s1_reg;
	end
end

////////////////////////////////////////////////////////////////////////
// core domain outputs and boot select capture

wire proc_ok = (state_reg == ST_RUN) | ((state_reg == ST_SW) & ~cmd_reg[0]);
wire periph_ok = (state_reg == ST_RUN) | ((state_reg == ST_SW) & ~cmd_reg[1]);

always @(posedge CORE_CLK or negedge core_rst_n) begin
	if (!core_rst_n) begin
		proc_n_reg <= 1'b0;
		periph_n_reg <= 1'b0;
		boot_cnt_reg <= 2'h0;
		boot_s1_reg <= 1'b0;
		boot_s2_reg <= 1'b0;
		boot_reg <= 1'b0;
	end else begin
		proc_n_reg <= proc_ok & core_ok_s2_reg;
		periph_n_reg <= periph_ok & core_ok_s2_reg;
		boot_s1_reg <= BOOT_SELECT_PIN;
		boot_s2_reg <= boot_s1_reg;
		if (boot_cnt_reg != `SRC_BOOT_CYC) begin
			boot_cnt_reg <= boot_cnt_reg + 2'h1;
		end
		if (boot_cnt_reg == `SRC_BOOT_CYC - 2'h1) begin
			boot_reg <= boot_s2_reg;
		end
	end
end

// pin drives low before release and for each programmed pulse
wire pin_hold = (state_reg == ST_START) | (state_reg == ST_GHOLD) |
	(state_reg == ST_CDOWN) | (state_reg == ST_WAKE);
reg pin_oe_reg;

always @(posedge CORE_CLK or negedge bu_rst_n) begin
	if (!bu_rst_n) begin
		pin_oe_reg <= 1'b1;
	end else begin
		pin_oe_reg <= pin_hold | (pulse_next != {CNT_W{1'b0}});
	end
end

assign PIN_RST_OUT = 1'b0;
assign PIN_RST_OE = pin_oe_reg;
assign BOOT_SELECT = boot_reg;
assign PROC_RESET_N = proc_n_reg;
assign PERIPH_RESET_N = periph_n_reg;
assign BACKUP_RESET_N = bu_out_reg;
assign USER_RESET_IRQ = seen_reg & ien_reg;

endmodule

// file: verification/src_pin_board.sv
`timescale 1ns/10ps
// board side of the reset pin: pull-up, and devices that may hold it low
module src_pin_board (
	input wire oe,
	input wire out,
	input wire hold,
	output wire pin
);
// a released pin goes back high through the pull-up, never keeps the old level
assign pin = (oe && !out) || hold ? 1'b0 : 1'b1;
endmodule

// file: verification/src_rc_assertions.sv
`timescale 1ns/10ps
module src_rc_chk (
	input wire CORE_CLK,
	input wire RESET_N,
	input wire BACKUP_POR_N,
	input wire CORE_POR_N,
	input wire PIN_RST_OE,
	input wire PROC_RESET_N,
	input wire BACKUP_RESET_N,
	input wire PERIPH_RESET_N,
	input wire USER_RESET_IRQ,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA
);
// busy state is not visible here, so commands are spaced apart by the bench
wire cmd_wr = PSEL && PENABLE && PWRITE && PADDR == 8'h00 && PROC_RESET_N;
wire key_ok = PWDATA[31:24] == 8'ha5;
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RESET_N);
//////////////////////////////////////////////
property p_bkp;
	!BACKUP_POR_N |-> !PROC_RESET_N && !BACKUP_RESET_N && !PERIPH_RESET_N && PIN_RST_OE;
endproperty
a_bkp: assert property (p_bkp) else $error("reset free in backup loss");
property p_core;
	!CORE_POR_N |-> !PROC_RESET_N && !PERIPH_RESET_N;
endproperty
a_core: assert property (p_core) else $error("reset free in core loss");
property p_order;
	!BACKUP_RESET_N |-> !PROC_RESET_N;
endproperty
a_order: assert property (p_order) else $error("core reset before backup");
property p_pin;
	$rose(BACKUP_RESET_N) |-> ##[2:3] !PIN_RST_OE;
endproperty
a_pin: assert property (p_pin) else $error("pin not released");
property p_wake;
	$rose(CORE_POR_N) |-> !PROC_RESET_N [*4] ##[1:4] PROC_RESET_N;
endproperty
a_wake: assert property (p_wake) else $error("wake release timing");
property p_sw;
	cmd_wr && key_ok && PWDATA[0] |-> ##2 !PROC_RESET_N ##1 !PROC_RESET_N ##1 PROC_RESET_N;
endproperty
a_sw: assert property (p_sw) else $error("software reset length");
property p_key;
	cmd_wr && !key_ok |-> ##2 PROC_RESET_N;
endproperty
a_key: assert property (p_key) else $error("bad key obeyed");
property p_irq;
	USER_RESET_IRQ && !(PSEL && PENABLE) |=> USER_RESET_IRQ;
endproperty
a_irq: assert property (p_irq) else $error("flag cleared without read");
endmodule
bind src_reset_ctrl src_rc_chk u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
	.BACKUP_POR_N(BACKUP_POR_N), .CORE_POR_N(CORE_POR_N), .PIN_RST_OE(PIN_RST_OE),
	.PROC_RESET_N(PROC_RESET_N), .BACKUP_RESET_N(BACKUP_RESET_N),
	.PERIPH_RESET_N(PERIPH_RESET_N), .USER_RESET_IRQ(USER_RESET_IRQ), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA));

// file: verification/tb_system_reset_controller.sv
`timescale 1ns/10ps
module tb_system_reset_controller;
logic clk = 0, rst_n = 0, bpor = 1, cpor = 1, hold = 0, bpin = 0, bs;
logic psel = 0, pen = 0, pwr = 0;
logic [7:0] paddr = 0;
logic [31:0] pwdata = 0;
logic [31:0] eq[$], mq[$];
wire pin, pout, oe, bsel, proc_n, bkp_n, per_n, irq, pready, perr;
wire [31:0] prdata;
int bad_count = 0, checks_done = 0, e, n, m;
always #4 clk = ~clk;
src_reset_ctrl #(.STARTUP_CYC(4)) u_src_reset_ctrl (.CORE_CLK(clk), .RESET_N(rst_n),
	.BACKUP_POR_N(bpor), .CORE_POR_N(cpor), .PIN_RST_IN(pin), .PIN_RST_OUT(pout),
	.PIN_RST_OE(oe), .BOOT_SELECT_PIN(bpin), .BOOT_SELECT(bsel), .PROC_RESET_N(proc_n),
	.BACKUP_RESET_N(bkp_n), .PERIPH_RESET_N(per_n), .USER_RESET_IRQ(irq), .PSEL(psel),
	.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
	.PREADY(pready), .PSLVERR(perr));
src_pin_board u_src_pin_board (.oe(oe), .out(pout), .hold(hold), .pin(pin));
//////////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] x);
	checks_done++;
	if (s !== x) begin
		bad_count++;
		$display("MISMATCH %0t seen %h expected %h", $time, s, x);
	end
endtask
task give_verdict;
	$display("mismatches %0d checks %0d", bad_count, checks_done);
	if (bad_count == 0 && checks_done > 0) $display("All checks passed");
	else $display("Checks failed");
	$finish;
endtask
// a read leaves its expected value and mask for the monitor
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
	@(posedge clk);
	psel <= 1;
	pwr <= w;
	paddr <= a;
	pwdata <= d;
	if (!w) begin
		eq.push_back(d);
		mq.push_back(m);
	end
	@(posedge clk);
	pen <= 1;
	@(posedge clk);
	while (pready !== 1'b1) @(posedge clk);
	psel <= 0;
	pen <= 0;
endtask
// wait for processor reset level, then four cycles, enough for a default-length pin pulse to run out
task wp(input logic v);
	n = 0;
	while (proc_n !== v && n < 300) begin
		@(negedge clk);
		n++;
	end
	chk(proc_n, v);
	repeat (4) @(negedge clk);
endtask
task board(input int k);
	@(posedge clk);
	hold <= 1;
	repeat (k) @(negedge clk);
endtask
always @(posedge clk) begin
	if (psel && pen && pready === 1'b1) begin
		chk(perr, !(paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08));
	end
	if (psel && pen && !pwr && pready === 1'b1 && eq.size() > 0) begin
		chk(prdata & mq[0], eq[0] & mq[0]);
		eq.delete(0);
		mq.delete(0);
	end
end
initial begin
	repeat (3000) @(posedge clk);
	bad_count++;
	give_verdict;
end
initial begin
	void'($urandom(32'h59d48d50));
	e = $urandom % 4;
	bs = 1'($urandom);
	repeat (3) @(posedge clk);
	rst_n <= 1;
	wp(1);
	xfer(0, 8'h04, 32'h1_0000, 32'h3_0700);
	xfer(0, 8'h08, 0, 32'hffff_ffff);
	xfer(0, 8'h0c, 0, 32'hffff_ffff);
	xfer(1, 8'h00, 32'h5a00_0005, 0);
	xfer(1, 8'h00, 32'ha500_0005, 0);
	repeat (2) @(negedge clk);
	chk({proc_n, per_n}, 0);
	wp(1);
	xfer(0, 8'h04, 32'h1_0300, 32'h3_0700);
	xfer(1, 8'h08, 32'ha500_0001 | (e << 8), 0);
	xfer(0, 8'h08, 32'h1 | (e << 8), 32'hffff_ffff);
	xfer(1, 8'h00, 32'ha500_0008, 0);
	n = 0;
	// busy must read back while the command is still in progress
	fork
		repeat (40) begin
			@(negedge clk);
			n += oe;
		end
		xfer(0, 8'h04, 32'h2_0000, 32'h2_0000);
	join
	chk(n, 2 << e);
	xfer(0, 8'h04, 32'h1_0301, 32'h3_0701);
	xfer(0, 8'h04, 32'h1_0300, 32'h3_0701);
	// held by the board well past the programmed pulse
	board(8);
	chk({proc_n, per_n}, 0);
	repeat (30) @(negedge clk);
	chk(proc_n, 0);
	xfer(0, 8'h04, 32'h1, 32'h1_0001);
	@(posedge clk);
	hold <= 0;
	wp(1);
	xfer(0, 8'h04, 32'h1_0400, 32'h3_0701);
	xfer(1, 8'h08, 32'ha500_0011 | (e << 8), 0);
	board(6);
	chk({irq, proc_n}, 2'b11);
	@(posedge clk);
	hold <= 0;
	xfer(0, 8'h04, 32'h1, 32'h1);
	@(negedge clk);
	chk(irq, 0);
	@(posedge clk);
	bpin <= bs;
	cpor <= 0;
	@(negedge clk);
	chk({proc_n, per_n, bkp_n}, 3'b001);
	repeat (3) @(posedge clk);
	cpor <= 1;
	m = 0;
	fork
		wp(1);
		repeat (40) begin
			@(negedge clk);
			m += oe;
		end
	join
	// pin held through resync and hold, then the programmed pulse
	chk(m, (2 << e) + 4);
	chk(bsel, bs);
	xfer(0, 8'h04, 32'h100, 32'h700);
	xfer(0, 8'h08, 32'h11 | (e << 8), 32'hffff_ffff);
	xfer(1, 8'h08, 32'ha500_0000, 0);
	board(8);
	chk({irq, proc_n}, 2'b01);
	@(posedge clk);
	hold <= 0;
	@(posedge clk);
	bpor <= 0;
	@(negedge clk);
	chk({proc_n, bkp_n, per_n, oe}, 4'b0001);
	@(posedge clk);
	bpor <= 1;
	wp(1);
	xfer(0, 8'h08, 0, 32'hffff_ffff);
	xfer(0, 8'h04, 32'h1_0000, 32'h3_0700);
	give_verdict;
end
endmodule
